//--- verilog/ssi_port.sv
// Synchronous serial port: SPI master/slave with slave-select sync, I2C slave.
// Assumes external open-drain resolution of SCL/SDA and pull-ups on the bus.
`timescale 1ns/1ps
`include "ssi_cfg.svh"
module ssi_port #(
   parameter int HALF_CYC = `SSI_HALF_CYC
) (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic ARST_N,
   // Configuration
   input wire ssi_pkg::ssi_ctrl_t CTRL,
   input wire logic [`SSI_ADDR_W-1:0] OWN_ADDR,
   input wire logic STRETCH_EN,
   input wire logic SLEEP,
   // Software data path
   input wire logic [`SSI_BYTE_W-1:0] WR_DATA,
   input wire logic WR_STB,
   input wire logic RD_STB,
   output logic [`SSI_BYTE_W-1:0] RD_DATA,
   output logic BUF_FULL,
   // Flags and their clears
   output logic INT_FLAG,
   input wire logic INT_CLR,
   output logic COLLISION,
   input wire logic COLLISION_CLR,
   output logic ARB_LOST,
   input wire logic ARB_CLR,
   input wire logic SCL_RELEASE,
   // SPI pins
   input wire ssi_pkg::ssi_spi_in_t SPI_IN,
   output logic SCK_OUT,
   output logic SDO,
   output logic SDO_OE,
   // I2C pins
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SCL_OUT,
   output logic SCL_OE,
   output logic SDA_OUT,
   output logic SDA_OE
);
   import ssi_pkg::*;

   logic [`SSI_SYNC_W-1:0] pin_s;
   logic sck_s, ss_n_s, sdi_s, scl_s, sda_s;
   ssi_sync3 #(.W(`SSI_SYNC_W), .INIT(`SSI_SYNC_INIT)) u_sync (
      .clk(CLOCK),
      .arst_n(ARST_N),
      .din({SPI_IN.sck, SPI_IN.ss_n, SPI_IN.sdi, SCL_IN, SDA_IN}),
      .dout(pin_s)
   );
   assign {sck_s, ss_n_s, sdi_s, scl_s, sda_s} = pin_s;

   logic en, spi_master, slave_ss, spi_slave, i2c, ss_idle;
   assign en = CTRL.enable;
   assign spi_master = en && CTRL.mode == `SSI_MODE_MASTER;
   assign slave_ss = en && CTRL.mode == `SSI_MODE_SLAVE_SS;
   assign spi_slave = slave_ss || (en && CTRL.mode == `SSI_MODE_SLAVE);
   assign i2c = en && CTRL.mode == `SSI_MODE_I2C_SLAVE;
   assign ss_idle = slave_ss && ss_n_s;

   // SPI and software-side state
   logic [7:0] sh_reg, sh_next, rx_reg, rx_next, txb_reg, txb_next, div_reg, div_next;
   logic [2:0] cnt_reg, cnt_next;
   logic mbusy_reg, mbusy_next, mdone_reg, mdone_next, mck_reg, mck_next;
   logic sck_prev_reg, sck_prev_next, bf_reg, bf_next, int_reg, int_next;
   logic coll_reg, coll_next, arb_reg, arb_next;
   logic sck_lvl, sample_ev, tick, spi_busy, shift_on;
   logic i2c_rx_ev, i2c_arb_ev;
   logic [7:0] i2c_rx_byte;

   assign sck_lvl = spi_master ? mck_reg : sck_s;
   assign sample_ev = sck_lvl != sck_prev_reg && sck_lvl == (CTRL.ckp ^ CTRL.cke);
   // Divider stops while asleep, so the master clock and shifter freeze in place
   assign tick = spi_master && mbusy_reg && !SLEEP && div_reg == 8'(HALF_CYC - 1);
   assign spi_busy = cnt_reg != 3'h0 || mbusy_reg;
   assign shift_on = spi_master ? mbusy_reg : spi_slave && !ss_idle;

   always_comb begin
      sh_next = sh_reg;
      rx_next = rx_reg;
      txb_next = txb_reg;
      cnt_next = cnt_reg;
      mbusy_next = mbusy_reg;
      mdone_next = mdone_reg;
      mck_next = mck_reg;
      div_next = div_reg;
      sck_prev_next = sck_lvl;
      bf_next = bf_reg && !RD_STB;
      int_next = int_reg && !INT_CLR;
      coll_next = coll_reg && !COLLISION_CLR;
      arb_next = arb_reg && !ARB_CLR;
      if (spi_master && mbusy_reg && !SLEEP) begin
         div_next = tick ? 8'h00 : div_reg + 8'h01;
      end
      if (tick) begin
         if (mdone_reg && mck_reg == CTRL.ckp) begin
            mbusy_next = 1'b0;
            mdone_next = 1'b0;
         end else begin
            mck_next = ~mck_reg;
         end
      end
      if (!mbusy_reg && !tick) begin
         mck_next = CTRL.ckp;
      end
      if (sample_ev && shift_on) begin
         sh_next = {sh_reg[6:0], sdi_s};
         cnt_next = cnt_reg + 3'h1;
         if (cnt_reg == `SSI_LAST_BIT) begin
            rx_next = {sh_reg[6:0], sdi_s};
            bf_next = 1'b1;
            int_next = 1'b1;
            mdone_next = spi_master;
         end
      end
      if (WR_STB) begin
         if ((spi_master || spi_slave) && (spi_busy || coll_reg)) begin
            coll_next = 1'b1;
         end else begin
            txb_next = WR_DATA;
            if (spi_master || spi_slave) begin
               sh_next = WR_DATA;
               mbusy_next = spi_master;
               div_next = 8'h00;
            end
         end
      end
      if (i2c_rx_ev) begin
         rx_next = i2c_rx_byte;
         bf_next = 1'b1;
         int_next = 1'b1;
      end
      if (i2c_arb_ev) begin
         arb_next = 1'b1;
      end
      // Select high or disable realigns the slave for the next transfer
      if (ss_idle || !en) begin
         cnt_next = 3'h0;
      end
      if (!en) begin
         mbusy_next = 1'b0;
         mdone_next = 1'b0;
         mck_next = CTRL.ckp;
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         sh_reg <= 8'h00;
         rx_reg <= 8'h00;
         txb_reg <= 8'h00;
         div_reg <= 8'h00;
         cnt_reg <= 3'h0;
         mbusy_reg <= 1'b0;
         mdone_reg <= 1'b0;
         mck_reg <= 1'b0;
         sck_prev_reg <= 1'b0;
         bf_reg <= 1'b0;
         int_reg <= 1'b0;
         coll_reg <= 1'b0;
         arb_reg <= 1'b0;
      end else begin
         sh_reg <= sh_next;
         rx_reg <= rx_next;
         txb_reg <= txb_next;
         div_reg <= div_next;
         cnt_reg <= cnt_next;
         mbusy_reg <= mbusy_next;
         mdone_reg <= mdone_next;
         mck_reg <= mck_next;
         sck_prev_reg <= sck_prev_next;
         bf_reg <= bf_next;
         int_reg <= int_next;
         coll_reg <= coll_next;
         arb_reg <= arb_next;
      end
   end

   // I2C slave state
   ssi_i2c_state_t ist_reg, ist_next;
   logic [3:0] icnt_reg, icnt_next;
   logic [7:0] ish_reg, ish_next;
   logic rw_reg, rw_next, sda_low_reg, sda_low_next, hold_reg, hold_next;
   logic scl_prev_reg, sda_prev_reg, scl_r, scl_f, start_ev, stop_ev, addr_hit;

   assign scl_r = scl_s && !scl_prev_reg;
   assign scl_f = !scl_s && scl_prev_reg;
   assign start_ev = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
   assign stop_ev = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
   assign addr_hit = ish_reg[7:1] == OWN_ADDR;
   assign i2c_rx_byte = ish_reg;

   always_comb begin
      ist_next = ist_reg;
      icnt_next = icnt_reg;
      ish_next = ish_reg;
      rw_next = rw_reg;
      sda_low_next = sda_low_reg;
      hold_next = hold_reg && !SCL_RELEASE;
      i2c_rx_ev = 1'b0;
      i2c_arb_ev = 1'b0;
      unique case (ist_reg)
         I_IDLE: ;
         I_ADDR, I_RX: begin
            if (scl_r && icnt_reg != `SSI_I2C_BITS) begin
               ish_next = {ish_reg[6:0], sda_s};
               icnt_next = icnt_reg + 4'h1;
            end else if (scl_f && icnt_reg == `SSI_I2C_BITS) begin
               if (ist_reg == I_RX || addr_hit) begin
                  ist_next = I_ACK;
                  sda_low_next = 1'b1;
                  rw_next = ist_reg == I_ADDR ? ish_reg[0] : rw_reg;
                  i2c_rx_ev = ist_reg == I_RX;
               end else begin
                  ist_next = I_IDLE;
               end
            end
         end
         I_ACK: begin
            if (scl_f) begin
               icnt_next = 4'h0;
               hold_next = STRETCH_EN;
               ist_next = rw_reg ? I_TX : I_RX;
               ish_next = txb_reg;
               sda_low_next = rw_reg && !txb_reg[7];
            end
         end
         I_TX: begin
            if (scl_r) begin
               if (!sda_low_reg && !sda_s) begin
                  ist_next = I_IDLE;
                  sda_low_next = 1'b0;
                  i2c_arb_ev = 1'b1;
               end else begin
                  icnt_next = icnt_reg + 4'h1;
                  ish_next = {ish_reg[6:0], 1'b0};
               end
            end else if (scl_f) begin
               sda_low_next = icnt_reg != `SSI_I2C_BITS && !ish_reg[7];
               ist_next = icnt_reg == `SSI_I2C_BITS ? I_TACK : I_TX;
            end
         end
         I_TACK: begin
            if (scl_r) begin
               icnt_next = 4'h0;
               ish_next = txb_reg;
               ist_next = sda_s ? I_IDLE : I_TX;
            end
         end
      endcase
      if (start_ev) begin
         ist_next = I_ADDR;
         icnt_next = 4'h0;
         sda_low_next = 1'b0;
      end
      if (stop_ev || !i2c) begin
         ist_next = I_IDLE;
         sda_low_next = 1'b0;
         hold_next = 1'b0;
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         ist_reg <= I_IDLE;
         icnt_reg <= 4'h0;
         ish_reg <= 8'h00;
         rw_reg <= 1'b0;
         sda_low_reg <= 1'b0;
         hold_reg <= 1'b0;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         ist_reg <= ist_next;
         icnt_reg <= icnt_next;
         ish_reg <= ish_next;
         rw_reg <= rw_next;
         sda_low_reg <= sda_low_next;
         hold_reg <= hold_next;
         scl_prev_reg <= scl_s;
         sda_prev_reg <= sda_s;
      end
   end

   assign RD_DATA = rx_reg;
   assign BUF_FULL = bf_reg;
   assign INT_FLAG = int_reg;
   assign COLLISION = coll_reg;
   assign ARB_LOST = arb_reg;
   assign SCK_OUT = mck_reg;
   assign SDO = sh_reg[7];
   assign SDO_OE = (spi_master || spi_slave) && !ss_idle;
   // Open-drain: only ever pull low
   assign SDA_OUT = 1'b0;
   assign SDA_OE = sda_low_reg;
   assign SCL_OUT = 1'b0;
   assign SCL_OE = hold_reg;

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!ARST_N);

   sequence s_addr_match;
      ist_reg == I_ADDR && scl_f && icnt_reg == `SSI_I2C_BITS && addr_hit && !start_ev && i2c;
   endsequence
   sequence s_last_sample;
      sample_ev && shift_on && cnt_reg == `SSI_LAST_BIT && en;
   endsequence

   a_ss_high_float: assert property (ss_idle |-> !SDO_OE) else $error("SDO driven with select high");
   a_ss_low_drive: assert property (slave_ss && !ss_n_s |-> SDO_OE) else $error("SDO not driven");
   a_ss_cnt_clear: assert property (ss_idle |=> cnt_reg == 3'h0) else $error("count kept");
   a_off_idle: assert property (!en |=> cnt_reg == 3'h0 && !mbusy_reg) else $error("not reset");
   a_write_collision_flag_set: assert property (WR_STB && spi_slave && spi_busy |=> COLLISION && $stable(txb_reg))
      else $error("collision not flagged");
   a_sleep_freeze: assert property (spi_master && SLEEP [*2] |-> $stable(mck_reg) && $stable(cnt_reg))
      else $error("master moved in sleep");
   a_byte_flag: assert property (s_last_sample |=> INT_FLAG && BUF_FULL && cnt_reg == 3'h0)
      else $error("byte flag missing");
   a_start_addr: assert property (start_ev && i2c |=> ist_reg == I_ADDR && !SDA_OE)
      else $error("start not taken");
   a_addr_ack: assert property (s_addr_match |=> ist_reg == I_ACK && SDA_OE)
      else $error("no acknowledge");
   a_arb_release: assert property (i2c_arb_ev && !stop_ev |=> !SDA_OE && ARB_LOST)
      else $error("arbitration not released");
endmodule

//--- verilog/ssi_cfg.svh
// Constants for the synchronous serial port: mode codes, reset values, timing.
// Assumes a 25 MHz system clock; included by the package and the port module.
`ifndef SSI_CFG_SVH
`define SSI_CFG_SVH

// Four-bit mode field codes
`define SSI_MODE_MASTER 4'h0
`define SSI_MODE_SLAVE_SS 4'h4
`define SSI_MODE_SLAVE 4'h5
`define SSI_MODE_I2C_SLAVE 4'h6

// Field widths and reset values
`define SSI_BYTE_W 8
`define SSI_ADDR_W 7
`define SSI_SYNC_W 5
`define SSI_SYNC_INIT 5'h1F
`define SSI_LAST_BIT 3'h7
`define SSI_I2C_BITS 4'h8

// Timing: system clock period and master serial clock half period
`define SSI_CLK_NS 40
`define SSI_HALF_NS 160
`define SSI_HALF_CYC ((`SSI_HALF_NS + `SSI_CLK_NS - 1) / `SSI_CLK_NS)

`endif

//--- verilog/ssi_pkg.sv
// Types shared by the synchronous serial port files.
// Assumes the constants header is on the include path.
package ssi_pkg;
   `include "ssi_cfg.svh"

   typedef struct packed {
      logic enable;
      logic [3:0] mode;
      logic ckp;
      logic cke;
      logic input_sample_phase;
   } ssi_ctrl_t;

   typedef struct packed {
      logic sck;
      logic ss_n;
      logic sdi;
   } ssi_spi_in_t;

   typedef enum logic [2:0] {I_IDLE, I_ADDR, I_ACK, I_RX, I_TX, I_TACK} ssi_i2c_state_t;
endpackage

//--- verilog/ssi_sync3.sv
// Three-stage input synchroniser with agreement filter, one lane per bit.
// Assumes asynchronous pin levels; output changes only when stages two and three agree.
`timescale 1ns/1ps
module ssi_sync3 #(
   parameter int W = 5,
   parameter logic [W-1:0] INIT = '1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Lanes
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   for (genvar i = 0; i < W; i++) begin : g_bit
      logic s1_reg, s2_reg, s3_reg, o_reg, o_next;
      always_comb begin
         o_next = (s2_reg == s3_reg) ? s3_reg : o_reg;
      end
      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            s1_reg <= INIT[i];
            s2_reg <= INIT[i];
            s3_reg <= INIT[i];
            o_reg <= INIT[i];
         end else begin
            s1_reg <= din[i];
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            o_reg <= o_next;
         end
      end
      assign dout[i] = o_reg;
   end
endmodule

//--- verification/ssi_far_master.sv
// Far-side model: SPI master on clock, select and data; I2C master on open-drain lines.
// Assumes the bench resolves the I2C wires with pull-ups and programs clock polarity low.
`timescale 1ns/1ps
module ssi_far_master (
   // SPI pins
   output logic sck,
   output logic ss_n,
   output logic sdi,
   input wire logic sdo,
   // I2C drives, high = released
   output logic scl_rel,
   output logic sda_rel,
   input wire logic sda
);
   localparam int HALF = 160;
   initial begin
      sck = 1'b0;
      ss_n = 1'b1;
      sdi = 1'b0;
      scl_rel = 1'b1;
      sda_rel = 1'b1;
   end
   // Shifts n bits MSB first; clock stands still outside the frame
   task automatic spi_frame(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      ss_n = 1'b0;
      #(2*HALF);
      for (int i = 0; i < n; i++) begin
         sdi = tx[7-i];
         #(HALF);
         rx = {rx[6:0], sdo};
         sck = 1'b1;
         #(HALF);
         sck = 1'b0;
      end
      #(2*HALF);
      ss_n = 1'b1;
      sdi = ~sdi; // Released line must not show a stale level
      #(2*HALF);
   endtask
   // Only called with both lines high, so the bus is idle first
   task automatic i2c_start;
      sda_rel = 1'b0;
      #(HALF);
      scl_rel = 1'b0;
      #(HALF);
   endtask
   task automatic i2c_stop;
      #(HALF/2);
      sda_rel = 1'b0;
      #(HALF);
      scl_rel = 1'b1;
      #(HALF);
      sda_rel = 1'b1;
      #(2*HALF);
   endtask
   // Repeated start from a low clock, keeping the bus
   task automatic i2c_restart;
      #(HALF/2);
      sda_rel = 1'b1;
      #(HALF);
      scl_rel = 1'b1;
      #(HALF);
      sda_rel = 1'b0;
      #(HALF);
      scl_rel = 1'b0;
      #(HALF);
   endtask
   // Eight data bits, then a released acknowledge slot sampled late in the high phase
   task automatic i2c_byte(input logic [7:0] b, output logic ack_n);
      for (int i = 0; i < 9; i++) begin
         #(HALF/2);
         sda_rel = (i < 8) ? b[7-i] : 1'b1;
         #(HALF);
         scl_rel = 1'b1;
         #(HALF);
         ack_n = sda;
         scl_rel = 1'b0;
      end
   endtask
endmodule

//--- verification/serial_port_ss_sync_i2c_bus_tb.sv
// Self-checking bench for the serial port: SPI slave with select, SPI master through sleep, then I2C slave.
// Assumes the far-side model file and the design files are compiled first.
`timescale 1ns/1ps
`include "ssi_cfg.svh"
module serial_port_ss_sync_i2c_bus_tb;
   import ssi_pkg::*;
   typedef struct packed {logic [7:0] tx; logic [7:0] back;} ssi_row_t;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   ssi_ctrl_t ctrl = '0;
   logic [6:0] own_addr = 7'h2A;
   logic [7:0] wr_data = 8'h00;
   logic [3:0] stb = 4'h0;
   logic tie0 = 1'b0;
   logic sleep = 1'b0;
   logic arb_lost, sck_o, m_sck;
   logic [7:0] rd_data, rx;
   logic buf_full, int_flag, collision, sdo, sdo_oe, scl_oe, sda_oe, a;
   logic sck, ss_n, sdi, scl_rel, sda_rel, scl, sda;
   ssi_row_t rows [4];
   int num_errors = 0;
   int n_checks = 0;
   always #20 clock = ~clock;
   // Open-drain wires with pull-ups
   assign scl = scl_rel & ~scl_oe;
   assign sda = sda_rel & ~sda_oe;
   ssi_port #(.HALF_CYC(1)) dut (
      .CLOCK(clock), .ARST_N(arst_n), .CTRL(ctrl), .OWN_ADDR(own_addr),
      .STRETCH_EN(tie0), .SLEEP(sleep), .WR_DATA(wr_data), .WR_STB(stb[3]),
      .RD_STB(stb[2]), .RD_DATA(rd_data), .BUF_FULL(buf_full), .INT_FLAG(int_flag),
      .INT_CLR(stb[1]), .COLLISION(collision), .COLLISION_CLR(stb[0]), .ARB_LOST(arb_lost),
      .ARB_CLR(tie0), .SCL_RELEASE(tie0), .SPI_IN({sck, ss_n, sdi}), .SCK_OUT(sck_o),
      .SDO(sdo), .SDO_OE(sdo_oe), .SCL_IN(scl), .SDA_IN(sda), .SCL_OUT(), .SCL_OE(scl_oe),
      .SDA_OUT(), .SDA_OE(sda_oe));
   ssi_far_master far (.sck(sck), .ss_n(ss_n), .sdi(sdi), .sdo(sdo),
      .scl_rel(scl_rel), .sda_rel(sda_rel), .sda(sda));
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Strobes: write, read, flag clear, collision clear
   task automatic sw(input logic [7:0] d, input logic [3:0] s);
      @(posedge clock);
      #1;
      wr_data = d;
      stb = s;
      @(posedge clock);
      #1;
      stb = 4'h0;
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #500000;
      num_errors++;
      report_and_stop();
   end
   initial begin
      rows[0] = '{8'h00, 8'hFF};
      rows[1] = '{8'hFF, 8'h00};
      rows[2] = '{8'hA5, 8'h5A};
      rows[3] = '{8'h81, 8'h3C};
      repeat (10) @(posedge clock);
      #1;
      arst_n = 1'b1;
      chk("sdo_oe_disabled", 8'(sdo_oe), 8'h00);
      // Clock-edge select needs select control; sample phase stays zero
      ctrl = '{1'b1, `SSI_MODE_SLAVE_SS, 1'b0, 1'b1, 1'b0};
      repeat (6) @(posedge clock);
      chk("sdo_oe_idle", 8'(sdo_oe), 8'h00);
      foreach (rows[i]) begin
         sw(rows[i].back, 4'h8);
         far.spi_frame(rows[i].tx, 8, rx);
         chk("rd_data", rd_data, rows[i].tx);
         chk("int_flag", 8'(int_flag), 8'h01);
         chk("buf_full", 8'(buf_full), 8'h01);
         chk("sdo_byte", rx, rows[i].back);
         sw(8'h00, 4'h6);
         chk("flags_clear", {6'h00, buf_full, int_flag}, 8'h00);
         $display("spi row %0d done", i);
      end
      // Partial byte then select high: output floats, counter realigns
      fork
         far.spi_frame(8'hF0, 3, rx);
         begin
            #1500;
            chk("sdo_oe_mid", 8'(sdo_oe), 8'h01);
         end
      join
      chk("sdo_oe_abort", 8'(sdo_oe), 8'h00);
      sw(8'hC3, 4'h8);
      chk("no_collision", 8'(collision), 8'h00);
      far.spi_frame(8'h3C, 8, rx);
      chk("realigned", rd_data, 8'h3C);
      chk("realigned_out", rx, 8'hC3);
      sw(8'h00, 4'h6);
      $display("spi abort test done");
      // Write during shifting is dropped
      sw(8'h96, 4'h8);
      fork
         far.spi_frame(8'h00, 8, rx);
         begin
            #1200;
            sw(8'h11, 4'h8);
         end
      join
      chk("collision", 8'(collision), 8'h01);
      chk("dropped_write", rx, 8'h96);
      sw(8'h22, 4'h8);
      chk("collision_held", 8'(collision), 8'h01);
      sw(8'h00, 4'h7);
      chk("collision_clr", 8'(collision), 8'h00);
      $display("spi collision test done");
      // Master byte frozen by sleep, finished after wake
      ctrl = '{1'b1, `SSI_MODE_MASTER, 1'b0, 1'b0, 1'b0};
      repeat (6) @(posedge clock);
      sw(8'h5A, 4'h8);
      sleep = 1'b1;
      m_sck = sck_o;
      repeat (20) @(posedge clock);
      chk("sleep_sck", 8'(sck_o), 8'(m_sck));
      chk("sleep_flag", 8'(int_flag), 8'h00);
      #1;
      sleep = 1'b0;
      repeat (40) @(posedge clock);
      chk("wake_flag", 8'(int_flag), 8'h01);
      sw(8'h00, 4'h6);
      $display("spi sleep test done");
      // I2C slave: matching write, then a foreign address
      ctrl = '{1'b1, `SSI_MODE_I2C_SLAVE, 1'b0, 1'b0, 1'b0};
      repeat (6) @(posedge clock);
      far.i2c_start();
      far.i2c_byte({7'h2A, 1'b0}, a);
      chk("addr_ack", 8'(a), 8'h00);
      far.i2c_byte(8'hA5, a);
      chk("data_ack", 8'(a), 8'h00);
      far.i2c_stop();
      chk("i2c_rd_data", rd_data, 8'hA5);
      chk("i2c_buf_full", 8'(buf_full), 8'h01);
      far.i2c_start();
      far.i2c_byte({7'h15, 1'b0}, a);
      chk("foreign_nack", 8'(a), 8'h01);
      far.i2c_stop();
      // Restart keeps the bus; then a read whose first bit loses arbitration
      sw(8'h80, 4'h8);
      far.i2c_start();
      far.i2c_byte({7'h2A, 1'b0}, a);
      far.i2c_restart();
      far.i2c_byte({7'h2A, 1'b0}, a);
      chk("restart_ack", 8'(a), 8'h00);
      far.i2c_restart();
      far.i2c_byte({7'h2A, 1'b1}, a);
      chk("read_ack", 8'(a), 8'h00);
      far.i2c_byte(8'h00, a);
      chk("arb_lost", 8'(arb_lost), 8'h01);
      far.i2c_stop();
      chk("sda_released", 8'(sda_oe), 8'h00);
      $display("i2c test done");
      report_and_stop();
   end
endmodule
